// ---- common/eeprom_pkg.sv ----
package eeprom_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  // longest self-timed write, rounded down to whole clocks
  localparam int WRITE_TIME_NS = 5000000;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
  // quarter of a serial clock period made by the host
  localparam int SCL_QTR_NS = 2500;
  localparam int SCL_QTR_CYCLES = SCL_QTR_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // array and control byte layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam int PAGE_W = 4;
  localparam int PAGE_SIZE = 16;
  localparam int CB_CODE_LSB = 4;
  localparam int CB_CS_LSB = 1;
  localparam int CB_RW_BIT = 0;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // device code: arbitrary value
  localparam logic [3:0] DEV_CODE = 4'h5;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ_CUR = 2'b01,
    OP_READ_RAND = 2'b10
  } op_t;

endpackage : eeprom_pkg

// ---- common/eeprom_link_if.sv ----
`timescale 1ns/1ps
interface eeprom_link_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic sda;

  // open-drain wire with pull-up: low if any end drives low
  assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

  modport device (
    input scl,
    input sda,
    output dev_sda_out,
    output dev_sda_oe_n
  );

  modport host (
    output scl,
    output host_sda_out,
    output host_sda_oe_n,
    input sda
  );
endinterface : eeprom_link_if

// ---- rtl/sync2.sv ----
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= INIT;
      q <= INIT;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : sync2

// ---- rtl/eeprom_dev.sv ----
`timescale 1ns/1ps
// What this block does
// - write control byte: code, selects, low bit
// - acknowledge matching write control byte, ninth pulse
// - next byte loads pointer, acknowledged
// - stop starts write cycle; no acks meanwhile
// - protected writes acknowledged, array unchanged
// - host waits full write time even protected
// - up to sixteen bytes buffered, committed at stop
// - data byte bumps low four pointer bits
// - over sixteen bytes wrap, overwrite buffered bytes
// - host keeps page writes inside one page
// - protect high blocks all writes, low allows
// - host polls start plus control until acked
// - after write cycle, polling byte is acknowledged
// - read control byte has read bit set
// - current read: ack, send byte at pointer
// - host nack and stop end reading; release
// - repeated start keeps pointer, abandons write
// - after random read pointer follows sent byte
// - host ack requests next sequential byte
// - pointer increments per read byte, wraps
// - respond only when selects match pins
module eeprom_dev #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
  parameter logic [3:0] DEV_CODE = eeprom_pkg::DEV_CODE
)
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  eeprom_link_if.device LINK,
  input wire logic CHIP_SELECT_IN_0,
  input wire logic CHIP_SELECT_IN_1,
  input wire logic CHIP_SELECT_IN_2,
  input wire logic WRITE_PROTECT,
  output logic BUSY
);
  import eeprom_pkg::*;

  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_CTRL = 3'b001,
    D_ADDR = 3'b010,
    D_WDATA = 3'b011,
    D_RACK = 3'b100,
    D_RDATA = 3'b101
  } dstate_t;

  // ---------------------------------------------------------------
  // pin sampling and bus conditions
  // ---------------------------------------------------------------
  logic [5:0] pin_raw;
  logic [5:0] pin_s;
  logic scl_d;
  logic sda_d;
  dstate_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [ADDR_W-1:0] ptr;
  logic ack_pend;
  logic have_data;
  logic [PAGE_SIZE-1:0] page_valid;
  logic sda_oe_n;
  logic [CNT_W-1:0] busy_cnt;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] page_buf [PAGE_SIZE];

  assign pin_raw = {LINK.scl, LINK.sda, CHIP_SELECT_IN_2, CHIP_SELECT_IN_1,
                    CHIP_SELECT_IN_0, WRITE_PROTECT};

  // idle bus reads high, so the synchroniser starts high on both lines
  sync2 #(.WIDTH(6), .INIT(6'h30)) u_pin_sync (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .d(pin_raw),
    .q(pin_s)
  );

  wire scl = pin_s[5];
  wire sda = pin_s[4];
  wire [2:0] cs = pin_s[3:1];
  wire wp = pin_s[0];

  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_seen = scl & scl_d & sda_d & ~sda;
  wire stop_seen = scl & scl_d & ~sda_d & sda;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire [7:0] rx_byte = {shift[6:0], sda};
  wire byte_done = scl_rise & (bit_cnt == 4'h7) & (state != D_IDLE);
  wire ack_rise = scl_rise & (bit_cnt == ACK_SLOT);
  wire busy_now = (busy_cnt != '0);
  wire code_ok = (rx_byte[CB_CODE_LSB +: 4] == DEV_CODE);
  wire cs_ok = (rx_byte[CB_CS_LSB +: 3] == cs);
  wire sel_ok = code_ok & cs_ok & ~busy_now;
  wire commit = stop_seen & (state == D_WDATA) & have_data;
  wire buf_wr = byte_done & (state == D_WDATA);
  wire [PAGE_W-1:0] low_inc = ptr[PAGE_W-1:0] + 4'h1;
  wire [ADDR_W-1:0] ptr_page_inc = {ptr[ADDR_W-1:PAGE_W], low_inc};
  wire [ADDR_W-1:0] ptr_inc = ptr + 8'h01;
  wire [2:0] tx_idx = 3'(4'h7 - bit_cnt);
  wire in_ack = (bit_cnt == ACK_SLOT);
  // while sending, the ack slot belongs to the host
  wire tx_oe_n = in_ack | tx[tx_idx];
  wire rx_oe_n = ~(in_ack & ack_pend);
  wire next_oe_n = (state == D_RDATA) ? tx_oe_n : rx_oe_n;

  assign LINK.dev_sda_out = 1'b0;
  assign LINK.dev_sda_oe_n = sda_oe_n;

  // ---------------------------------------------------------------
  // edge history
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state <= D_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'hFF;
      ptr <= '0;
      ack_pend <= 1'b0;
      have_data <= 1'b0;
      page_valid <= '0;
    end
    else if (start_seen || stop_seen)
    begin
      // a repeated start drops the write but keeps the pointer
      state <= start_seen ? D_CTRL : D_IDLE;
      bit_cnt <= 4'h0;
      ack_pend <= 1'b0;
      have_data <= 1'b0;
      page_valid <= '0;
    end
    else if (scl_rise && state != D_IDLE)
    begin
      shift <= rx_byte;
      bit_cnt <= in_ack ? 4'h0 : bit_cnt + 4'h1;
      if (byte_done)
      begin
        unique case (state)
          D_CTRL:
          begin
            ack_pend <= sel_ok;
            if (!sel_ok)
              state <= D_IDLE;
            else if (rx_byte[CB_RW_BIT] == RW_READ)
            begin
              state <= D_RACK;
              tx <= mem[ptr];
              ptr <= ptr_inc;
            end
            else
              state <= D_ADDR;
          end
          D_ADDR:
          begin
            ptr <= rx_byte;
            ack_pend <= 1'b1;
            state <= D_WDATA;
          end
          D_WDATA:
          begin
            // acked whatever the protect level
            ack_pend <= 1'b1;
            have_data <= 1'b1;
            page_valid[ptr[PAGE_W-1:0]] <= 1'b1;
            ptr <= ptr_page_inc;
          end
          default:
            ack_pend <= 1'b0;
        endcase
      end
      if (ack_rise && state == D_RACK)
        state <= D_RDATA;
      else if (ack_rise && state == D_RDATA)
      begin
        if (sda)
          state <= D_IDLE;
        else
        begin
          tx <= mem[ptr];
          ptr <= ptr_inc;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // data line drive, changed after the clock falls, released at start or stop
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      sda_oe_n <= 1'b1;
    else if (start_seen || stop_seen)
      sda_oe_n <= 1'b1;
    else if (scl_fall)
      sda_oe_n <= next_oe_n;
  end

  // ---------------------------------------------------------------
  // page buffer and array, no reset: contents are undefined at power-up
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (buf_wr)
      page_buf[ptr[PAGE_W-1:0]] <= rx_byte;
    if (commit && !wp)
    begin
      for (int i = 0; i < PAGE_SIZE; i++)
      begin
        if (page_valid[i])
          mem[{ptr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_buf[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // self-timed write cycle, runs even when the array is protected
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      busy_cnt <= '0;
      BUSY <= 1'b0;
    end
    else if (commit)
    begin
      busy_cnt <= CNT_W'(WRITE_CYCLES);
      BUSY <= 1'b1;
    end
    else if (busy_now)
    begin
      busy_cnt <= busy_cnt - CNT_W'(1);
      BUSY <= (busy_cnt != CNT_W'(1));
    end
  end
endmodule : eeprom_dev

// ---- rtl/eeprom_host.sv ----
`timescale 1ns/1ps
module eeprom_host #(
  parameter int QTR_CYCLES = eeprom_pkg::SCL_QTR_CYCLES,
  parameter logic [3:0] DEV_CODE = eeprom_pkg::DEV_CODE
)
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  eeprom_link_if.host LINK,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire eeprom_pkg::op_t CMD_OP,
  input wire logic [2:0] CMD_CS,
  input wire logic [7:0] CMD_ADDR,
  input wire logic [4:0] CMD_LEN,
  input wire logic [7:0] WR_DATA,
  output logic WR_TAKE,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic DONE,
  output logic ERR
);
  import eeprom_pkg::*;

  localparam int QW = $clog2(QTR_CYCLES + 1);

  typedef enum logic [1:0] {
    Y_START = 2'b00,
    Y_STOP = 2'b01,
    Y_BYTE = 2'b10
  } sym_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'h0,
    H_START = 4'h1,
    H_CTRL = 4'h2,
    H_ADDR = 4'h3,
    H_WDATA = 4'h4,
    H_RSTART = 4'h5,
    H_RCTRL = 4'h6,
    H_RDATA = 4'h7,
    H_STOP = 4'h8,
    H_RETRY = 4'h9
  } step_t;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [QW-1:0] qcnt;
  logic [1:0] phase;
  logic eng_busy;
  sym_t sym;
  step_t step;
  logic [8:0] tx9;
  logic [8:0] rx9;
  logic [3:0] nbit;
  logic scl;
  logic sda_oe_n;
  logic polling;
  op_t op;
  logic [2:0] cs;
  logic [7:0] addr;
  logic [4:0] left;
  logic sda_s;

  sync2 #(.WIDTH(1), .INIT(1'b1)) u_sda_sync (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .d(LINK.sda),
    .q(sda_s)
  );

  wire tick = eng_busy & (qcnt == QW'(QTR_CYCLES - 1));
  wire sym_end = tick & (phase == 2'h3) & ((sym != Y_BYTE) | (nbit == ACK_SLOT));
  wire nack = rx9[0];
  wire [7:0] ctrl_w = {DEV_CODE, cs, RW_WRITE};
  wire [7:0] ctrl_r = {DEV_CODE, cs, RW_READ};
  wire [8:0] rd_slot = {8'hFF, left == 5'h1};
  // writes are clipped at the page end instead of wrapping
  wire [4:0] page_room = 5'h10 - {1'b0, CMD_ADDR[PAGE_W-1:0]};
  wire [4:0] len_min = (CMD_LEN == 5'h0) ? 5'h1 : CMD_LEN;
  wire clip = (CMD_OP == OP_WRITE) & (len_min > page_room);
  wire [4:0] len_eff = clip ? page_room : len_min;

  assign LINK.scl = scl;
  assign LINK.host_sda_out = 1'b0;
  assign LINK.host_sda_oe_n = sda_oe_n;

  task automatic launch(input sym_t s, input logic [8:0] w);
    sym <= s;
    tx9 <= w;
    nbit <= 4'h0;
    phase <= 2'h0;
    qcnt <= '0;
    eng_busy <= 1'b1;
  endtask : launch

  // ---------------------------------------------------------------
  // bit engine and transfer sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      qcnt <= '0;
      phase <= 2'h0;
      eng_busy <= 1'b0;
      sym <= Y_STOP;
      step <= H_IDLE;
      tx9 <= 9'h1FF;
      rx9 <= 9'h1FF;
      nbit <= 4'h0;
      scl <= 1'b1;
      sda_oe_n <= 1'b1;
      polling <= 1'b0;
      op <= OP_WRITE;
      cs <= 3'h0;
      addr <= 8'h00;
      left <= 5'h0;
      CMD_READY <= 1'b1;
      WR_TAKE <= 1'b0;
      RD_DATA <= 8'h00;
      RD_VALID <= 1'b0;
      DONE <= 1'b0;
      ERR <= 1'b0;
    end
    else
    begin
      WR_TAKE <= 1'b0;
      RD_VALID <= 1'b0;
      DONE <= 1'b0;
      if (eng_busy)
        qcnt <= tick ? '0 : qcnt + QW'(1);
      if (tick)
      begin
        phase <= phase + 2'h1;
        // data changes a quarter after the clock falls, sampled mid-high
        unique case (phase)
          2'h0: sda_oe_n <= (sym == Y_STOP) ? 1'b0 : ((sym == Y_START) | tx9[8]);
          2'h1: scl <= 1'b1;
          2'h2:
          begin
            if (sym == Y_BYTE)
              rx9 <= {rx9[7:0], sda_s};
            else
              sda_oe_n <= (sym == Y_STOP);
          end
          2'h3:
          begin
            if (sym != Y_STOP)
              scl <= 1'b0;
            tx9 <= {tx9[7:0], 1'b1};
            nbit <= nbit + 4'h1;
          end
        endcase
      end
      if (sym_end)
        eng_busy <= 1'b0;
      if (CMD_VALID && CMD_READY)
      begin
        op <= CMD_OP;
        cs <= CMD_CS;
        addr <= CMD_ADDR;
        left <= len_eff;
        polling <= 1'b0;
        ERR <= 1'b0;
        CMD_READY <= 1'b0;
        step <= H_START;
        launch(Y_START, 9'h1FF);
      end
      if (sym_end)
      begin
        unique case (step)
          H_START:
          begin
            step <= H_CTRL;
            launch(Y_BYTE, {(op == OP_READ_CUR && !polling) ? ctrl_r : ctrl_w, 1'b1});
          end
          H_RETRY:
          begin
            step <= H_START;
            launch(Y_START, 9'h1FF);
          end
          H_CTRL:
          begin
            if (nack || polling)
            begin
              // no ack means busy: stop and send the control byte again
              step <= nack ? H_RETRY : H_STOP;
              launch(Y_STOP, 9'h1FF);
            end
            else if (op == OP_READ_CUR)
            begin
              step <= H_RDATA;
              left <= left - 5'h1;
              launch(Y_BYTE, rd_slot);
            end
            else
            begin
              step <= H_ADDR;
              launch(Y_BYTE, {addr, 1'b1});
            end
          end
          H_ADDR:
          begin
            if (nack)
            begin
              ERR <= 1'b1;
              step <= H_STOP;
              launch(Y_STOP, 9'h1FF);
            end
            else if (op == OP_WRITE)
            begin
              WR_TAKE <= 1'b1;
              left <= left - 5'h1;
              step <= H_WDATA;
              launch(Y_BYTE, {WR_DATA, 1'b1});
            end
            else
            begin
              step <= H_RSTART;
              launch(Y_START, 9'h1FF);
            end
          end
          H_RSTART:
          begin
            step <= H_RCTRL;
            launch(Y_BYTE, {ctrl_r, 1'b1});
          end
          H_WDATA, H_RCTRL:
          begin
            if (nack)
            begin
              ERR <= 1'b1;
              step <= H_STOP;
              launch(Y_STOP, 9'h1FF);
            end
            else if (step == H_RCTRL)
            begin
              step <= H_RDATA;
              left <= left - 5'h1;
              launch(Y_BYTE, rd_slot);
            end
            else if (left != 5'h0)
            begin
              WR_TAKE <= 1'b1;
              left <= left - 5'h1;
              launch(Y_BYTE, {WR_DATA, 1'b1});
            end
            else
            begin
              polling <= 1'b1;
              step <= H_RETRY;
              launch(Y_STOP, 9'h1FF);
            end
          end
          H_RDATA:
          begin
            RD_DATA <= rx9[8:1];
            RD_VALID <= 1'b1;
            if (left != 5'h0)
            begin
              left <= left - 5'h1;
              launch(Y_BYTE, rd_slot);
            end
            else
            begin
              step <= H_STOP;
              launch(Y_STOP, 9'h1FF);
            end
          end
          H_STOP:
          begin
            step <= H_IDLE;
            DONE <= 1'b1;
            CMD_READY <= 1'b1;
          end
          default:
            step <= H_IDLE;
        endcase
      end
    end
  end
endmodule : eeprom_host

// ---- verif/eeprom_link_properties.sv ----
`timescale 1ns/1ps
module eeprom_link_properties #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
  parameter logic [3:0] DEV_CODE = eeprom_pkg::DEV_CODE
)
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic scl,
  input wire logic host_sda_out,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  input wire logic sda,
  input wire logic BUSY
);
  import eeprom_pkg::*;
  // ---------------------------------------------------------------
  // bus phase tracking
  // ---------------------------------------------------------------
  logic scl_q, sda_q, first_byte, rd_op;
  logic [3:0] bit_idx, stop_age;
  int busy_len;
  wire logic scl_rise = scl & ~scl_q;
  wire logic start_cond = scl & scl_q & sda_q & ~sda;
  wire logic stop_cond = scl & scl_q & ~sda_q & sda;
  wire logic [3:0] next_bit = (bit_idx == ACK_SLOT) ? 4'h0 : bit_idx + 4'h1;
  always_ff @(posedge SYS_CLK or negedge RESET_N)
    if (!RESET_N)
      {scl_q, sda_q, first_byte, rd_op, bit_idx} <= {4'hC, 4'h0};
    else
    begin
      {scl_q, sda_q} <= {scl, sda};
      if (start_cond)
        {first_byte, bit_idx} <= {1'b1, 4'h0};
      else if (scl_rise)
        {first_byte, bit_idx} <= {first_byte & (bit_idx != ACK_SLOT), next_bit};
      if (scl_rise && first_byte && bit_idx == 4'h7)
        rd_op <= sda;
    end
  // counters kept apart so a stuck busy cannot hide in the bit tracking
  always_ff @(posedge SYS_CLK or negedge RESET_N)
    if (!RESET_N)
      {busy_len, stop_age} <= {32'h0, 4'hF};
    else
    begin
      busy_len <= BUSY ? busy_len + 1 : 0;
      stop_age <= stop_cond ? 4'h0 : stop_age + {3'h0, stop_age != 4'hF};
    end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  chk_busy_no_ack: assert property (BUSY |-> dev_sda_oe_n)
    else $error("device drove sda while busy");
  chk_busy_length: assert property ($fell(BUSY) |-> busy_len == WRITE_CYCLES)
    else $error("write cycle length wrong");
  chk_busy_bound: assert property (busy_len <= WRITE_CYCLES)
    else $error("write cycle too long");
  chk_busy_after_stop: assert property ($rose(BUSY) |-> stop_age <= 4'h6)
    else $error("write cycle not started by stop");
  chk_drive_scl_low: assert property ($fell(dev_sda_oe_n) |-> !scl)
    else $error("device took sda while scl high");
  chk_ack_held: assert property (scl && scl_q && !$past(dev_sda_oe_n) |-> !dev_sda_oe_n)
    else $error("device let go of sda while scl high");
  chk_write_ack_slot: assert property (scl_rise && (first_byte || !rd_op) && !dev_sda_oe_n
    |-> bit_idx == ACK_SLOT)
    else $error("device drove outside the ack pulse");
  chk_read_ack_free: assert property (scl_rise && !first_byte && rd_op && bit_idx == ACK_SLOT
    |-> dev_sda_oe_n)
    else $error("device held sda in host ack pulse");
  chk_ctrl_code: assert property (scl_rise && first_byte && bit_idx < 4'h4
    |-> sda == DEV_CODE[4'h3 - bit_idx])
    else $error("control byte code wrong");
endmodule : eeprom_link_properties

// ---- verif/serial_eeprom_rw_control_test.sv ----
`timescale 1ns/1ps
module serial_eeprom_rw_control_test;
  import eeprom_pkg::*;
  // ---------------------------------------------------------------
  // set-up
  // ---------------------------------------------------------------
  localparam int WCYC = 200;
  localparam int LIMIT = 40000;
  typedef struct {op_t op; logic [2:0] cs; logic [7:0] addr; logic [4:0] len; logic wp;} row_t;
  logic SYS_CLK = 1'b0, RESET_N = 1'b0, CMD_VALID = 1'b0, WRITE_PROTECT = 1'b0;
  logic CHIP_SELECT_IN_0 = 1'b0, CHIP_SELECT_IN_1 = 1'b0, CHIP_SELECT_IN_2 = 1'b0;
  op_t CMD_OP = OP_WRITE;
  logic [2:0] CMD_CS = 3'h0;
  logic [7:0] CMD_ADDR = 8'h00, WR_DATA = 8'h00, RD_DATA, ptr = 8'h00;
  logic [4:0] CMD_LEN = 5'h00;
  logic CMD_READY, WR_TAKE, RD_VALID, DONE, ERR, BUSY, busy_seen = 1'b0, dev_drove = 1'b0;
  logic [7:0] mem [256], wbuf [17], rbuf [32];
  row_t rows [9];
  int widx = 0, ridx = 0, failures = 0, check_count = 0, cycles = 0;
  eeprom_link_if link ();
  eeprom_dev #(.WRITE_CYCLES(WCYC), .DEV_CODE(DEV_CODE)) i_eeprom_dev (.SYS_CLK(SYS_CLK),
    .RESET_N(RESET_N), .LINK(link.device), .CHIP_SELECT_IN_0(CHIP_SELECT_IN_0),
    .CHIP_SELECT_IN_1(CHIP_SELECT_IN_1), .CHIP_SELECT_IN_2(CHIP_SELECT_IN_2),
    .WRITE_PROTECT(WRITE_PROTECT), .BUSY(BUSY));
  eeprom_host #(.QTR_CYCLES(4), .DEV_CODE(DEV_CODE)) i_eeprom_host (.SYS_CLK(SYS_CLK),
    .RESET_N(RESET_N), .LINK(link.host), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
    .CMD_OP(CMD_OP), .CMD_CS(CMD_CS), .CMD_ADDR(CMD_ADDR), .CMD_LEN(CMD_LEN),
    .WR_DATA(WR_DATA), .WR_TAKE(WR_TAKE), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
    .DONE(DONE), .ERR(ERR));
  eeprom_link_properties #(.WRITE_CYCLES(WCYC), .DEV_CODE(DEV_CODE)) i_eeprom_link_properties (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .scl(link.scl), .host_sda_out(link.host_sda_out),
    .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_out(link.dev_sda_out),
    .dev_sda_oe_n(link.dev_sda_oe_n), .sda(link.sda), .BUSY(BUSY));
  always #25 SYS_CLK = ~SYS_CLK;
  // ---------------------------------------------------------------
  // user-side helpers
  // ---------------------------------------------------------------
  always @(posedge SYS_CLK)
  begin
    cycles <= cycles + 1;
    if (WR_TAKE === 1'b1)
      {widx, WR_DATA} <= {widx + 1, wbuf[widx + 1]};
    if (RD_VALID === 1'b1)
      {ridx, rbuf[ridx]} <= {ridx + 1, RD_DATA};
    if (BUSY === 1'b1)
      busy_seen <= 1'b1;
    if (link.dev_sda_oe_n === 1'b0)
      dev_drove <= 1'b1;
    if (cycles == LIMIT)
    begin
      failures++;
      $display("[FAIL] %0t run too long", $time);
      close_out();
    end
  end
  task check(input bit ok, input string what);
    check_count++;
    if (!ok)
    begin
      failures++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check
  task close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task reset_check();
    check(CMD_READY === 1'b1 && ERR === 1'b0 && BUSY === 1'b0, "reset outputs");
    check(link.scl === 1'b1 && link.sda === 1'b1, "bus not idle in reset");
  endtask : reset_check
  task issue(input row_t r);
    @(posedge SYS_CLK);
    {CHIP_SELECT_IN_2, CHIP_SELECT_IN_1, CHIP_SELECT_IN_0} <= r.cs;
    WRITE_PROTECT <= r.wp;
    dev_drove <= 1'b0;
    // pins pass a synchroniser before the device sees them
    repeat (4) @(posedge SYS_CLK);
    // enum target kept out of the concatenation
    CMD_OP <= r.op;
    {CMD_VALID, CMD_CS, CMD_ADDR, CMD_LEN} <= {1'b1, r.cs, r.addr, r.len};
    {widx, WR_DATA, ridx, busy_seen} <= {32'h0, wbuf[0], 32'h0, 1'b0};
    @(posedge SYS_CLK);
    CMD_VALID <= 1'b0;
  endtask : issue
  task do_cmd(input row_t r, input int k);
    int n, i, t;
    logic [7:0] base;
    n = (r.len == 5'h00) ? 1 : int'(r.len);
    if (r.op == OP_WRITE && int'(r.addr[3:0]) + n > PAGE_SIZE)
      n = PAGE_SIZE - int'(r.addr[3:0]);
    for (i = 0; i < 17; i++)
      wbuf[i] = 8'(k * 37 + i * 5 + 3);
    issue(r);
    t = 0;
    do
    begin
      @(negedge SYS_CLK);
      t++;
    end while (DONE !== 1'b1 && t < 20000);
    check(DONE === 1'b1 && ERR === 1'b0 && CMD_READY === 1'b1, "command end");
    check(BUSY === 1'b0, "busy after done");
    if (r.op == OP_WRITE)
    begin
      check(busy_seen === 1'b1, "no write cycle");
      for (i = 0; i < n; i++)
        if (!r.wp)
          mem[r.addr + 8'(i)] = wbuf[i];
      ptr = {r.addr[7:4], r.addr[3:0] + 4'(n)};
    end
    else
    begin
      base = (r.op == OP_READ_CUR) ? ptr : r.addr;
      check(ridx == n, "read byte count");
      for (i = 0; i < n; i++)
        check(rbuf[i] === mem[base + 8'(i)], "read data");
      ptr = base + 8'(n);
    end
    $display("test %0d done", k);
  endtask : do_cmd
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rows[0] = '{OP_WRITE, 3'h5, 8'hF8, 5'h08, 1'b0};
    rows[1] = '{OP_WRITE, 3'h2, 8'h00, 5'h10, 1'b0};
    // current read right after a full page write: pointer must stay in the page
    rows[2] = '{OP_READ_CUR, 3'h4, 8'h00, 5'h02, 1'b0};
    rows[3] = '{OP_READ_RAND, 3'h7, 8'hFC, 5'h08, 1'b0};
    rows[4] = '{OP_READ_CUR, 3'h0, 8'h00, 5'h02, 1'b0};
    rows[5] = '{OP_WRITE, 3'h5, 8'h04, 5'h02, 1'b1};
    rows[6] = '{OP_READ_RAND, 3'h1, 8'h04, 5'h02, 1'b1};
    rows[7] = '{OP_WRITE, 3'h6, 8'h3A, 5'h08, 1'b0};
    rows[8] = '{OP_READ_RAND, 3'h3, 8'h3A, 5'h06, 1'b0};
    repeat (5) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    reset_check();
    @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    for (int k = 0; k < 9; k++)
      do_cmd(rows[k], k);
    // selects differ from pins: host keeps retrying, device stays silent
    // the host latches its selects at the take edge, so the pins move instead
    issue('{OP_READ_CUR, 3'h3, 8'h00, 5'h01, 1'b0});
    {CHIP_SELECT_IN_2, CHIP_SELECT_IN_1, CHIP_SELECT_IN_0} <= 3'h4;
    repeat (1500) @(negedge SYS_CLK);
    check(dev_drove === 1'b0 && CMD_READY === 1'b0, "foreign select answered");
    $display("test select done");
    @(posedge SYS_CLK);
    RESET_N <= 1'b0;
    repeat (6) @(negedge SYS_CLK);
    reset_check();
    $display("test reset done");
    @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    ptr = 8'h00;
    do_cmd('{OP_READ_CUR, 3'h3, 8'h00, 5'h02, 1'b0}, 9);
    close_out();
  end
endmodule : serial_eeprom_rw_control_test
